// ==== tmv_pkg.sv ====
// Constants, types and decode helpers for the timer channel value block
package tmv_pkg;
  localparam int NCH         = 6;
  localparam int IDX_W       = 7;
  localparam int BYTE_ADDR_W = 9;
  localparam int CTRL_W      = 6;
  localparam int VAL_W       = 16;
  localparam int BYTE_W      = 8;
  localparam int HI_LSB      = 8;

  // Register indices, byte address is four times the index
  localparam logic [IDX_W-1:0] VAL_HI_IDX [NCH] =
    '{7'h27, 7'h2a, 7'h2d, 7'h30, 7'h33, 7'h36};
  localparam logic [IDX_W-1:0] VAL_LO_IDX [NCH] =
    '{7'h28, 7'h2b, 7'h2e, 7'h31, 7'h34, 7'h37};
  localparam logic [IDX_W-1:0] CTRL_IDX [NCH] =
    '{7'h38, 7'h39, 7'h3a, 7'h3b, 7'h3c, 7'h3d};
  localparam logic [IDX_W-1:0] STATUS_IDX = 7'h40;
  localparam logic [IDX_W-1:0] CLEAR_IDX  = 7'h41;
  localparam logic [IDX_W-1:0] ENABLE_IDX = 7'h42;

  // Control register fields
  localparam int FD_BIT  = 0;
  localparam int TOV_BIT = 1;
  localparam int ELS_LSB = 2;
  localparam int MSA_BIT = 4;
  localparam int MSB_BIT = 5;
  localparam logic [CTRL_W-1:0] CTRL_RST = 6'h00;
  localparam logic [NCH-1:0]    IRQ_RST  = 6'h00;
  localparam logic              OUT_RST  = 1'b1;

  localparam logic [1:0] ELS_OFF = 2'h0;
  localparam logic [1:0] ELS_TOG = 2'h1;
  localparam logic [1:0] ELS_CLR = 2'h2;
  localparam logic [1:0] ELS_SET = 2'h3;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum {MODE_PORT, MODE_CAPTURE, MODE_COMPARE, MODE_BUFFERED}
    tmv_mode_t;

  // Channel mode from its control bits
  function automatic tmv_mode_t tmv_mode(input logic [CTRL_W-1:0] c);
    if (c[ELS_LSB+1:ELS_LSB] == ELS_OFF)
      return MODE_PORT;
    else if (c[MSB_BIT])
      return MODE_BUFFERED;
    else if (c[MSA_BIT])
      return MODE_COMPARE;
    else
      return MODE_CAPTURE;
  endfunction
endpackage

// ==== tmv_reg_if.sv ====
// Register access carrier between bus slave and register file
`timescale 1ns/1ps
interface tmv_reg_if;
  import tmv_pkg::*;
  logic             wr;
  logic             rd;
  logic [IDX_W-1:0] idx;
  logic [7:0]       wdata;
  logic [7:0]       rdata;
  logic             hit;
  modport bus  (output wr, rd, idx, wdata, input rdata, hit);
  modport regs (input wr, rd, idx, wdata, output rdata, hit);
endinterface

// ==== tmv_axil.sv ====
// AXI4-Lite slave front end for the channel value block
`timescale 1ns/1ps
module tmv_axil
  import tmv_pkg::*;
(
  input  wire logic                   aclk,
  input  wire logic                   aresetn,
  input  wire logic [BYTE_ADDR_W-1:0] awaddr,
  input  wire logic                   awvalid,
  output logic                        awready,
  input  wire logic [31:0]            wdata,
  input  wire logic [3:0]             wstrb,
  input  wire logic                   wvalid,
  output logic                        wready,
  output logic [1:0]                  bresp,
  output logic                        bvalid,
  input  wire logic                   bready,
  input  wire logic [BYTE_ADDR_W-1:0] araddr,
  input  wire logic                   arvalid,
  output logic                        arready,
  output logic [31:0]                 rdata,
  output logic [1:0]                  rresp,
  output logic                        rvalid,
  input  wire logic                   rready,
  tmv_reg_if.bus                      rif
);
  logic wr_go;
  logic rd_go;

  // Address and data taken together; a write beats a read
  assign wr_go     = awvalid && wvalid && !bvalid;
  assign rd_go     = arvalid && !rvalid && !wr_go;
  assign awready   = wr_go;
  assign wready    = wr_go;
  assign arready   = rd_go;
  assign rif.wr    = wr_go && wstrb[0];  // Only lane 0 carries data
  assign rif.rd    = rd_go;
  assign rif.idx   = wr_go ? awaddr[BYTE_ADDR_W-1:2]
                           : araddr[BYTE_ADDR_W-1:2];
  assign rif.wdata = wdata[BYTE_W-1:0];

  // Write response
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      bvalid <= 1'b0;
      bresp  <= RESP_OKAY;
    end
    else if (wr_go)
    begin
      bvalid <= 1'b1;
      bresp  <= rif.hit ? RESP_OKAY : RESP_SLVERR;
    end
    else if (bready)
      bvalid <= 1'b0;
  end

  // Read response, upper bits read as zero
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rvalid <= 1'b0;
      rdata  <= 32'h0000_0000;
      rresp  <= RESP_OKAY;
    end
    else if (rd_go)
    begin
      rvalid <= 1'b1;
      rdata  <= {24'h00_0000, rif.rdata};
      rresp  <= rif.hit ? RESP_OKAY : RESP_SLVERR;
    end
    else if (rready)
      rvalid <= 1'b0;
  end
endmodule // tmv_axil

// ==== tmv_chan_out.sv ====
// Channel output level with overflow toggle and full-duty override
`timescale 1ns/1ps
module tmv_chan_out
  import tmv_pkg::*;
(
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic [CTRL_W-1:0] ctrl,
  input  wire logic              overflow,
  input  wire logic              match,
  output logic                   pwm
);
  logic      fd_active;
  logic      next_fd;
  logic      tov;
  logic [1:0] els;
  tmv_mode_t mode;

  assign tov     = ctrl[TOV_BIT];
  assign els     = ctrl[ELS_LSB+1:ELS_LSB];
  assign mode    = tmv_mode(ctrl);
  // Force bit sampled only at the period boundary
  assign next_fd = overflow ? ctrl[FD_BIT] : fd_active;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      fd_active <= 1'b0;
    else
      fd_active <= next_fd;
  end

  // Output level; overflow toggle outranks a match
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      pwm <= OUT_RST;
    else
      case (mode)
        MODE_PORT:
          pwm <= !ctrl[MSA_BIT];
        MODE_COMPARE, MODE_BUFFERED:
          if (next_fd && !tov)
            pwm <= 1'b1;
          else if (overflow && tov)
            pwm <= !pwm;
          else if (match)
            case (els)
              ELS_TOG: pwm <= !pwm;
              ELS_CLR: pwm <= 1'b0;
              ELS_SET: pwm <= 1'b1;
              default: pwm <= pwm;
            endcase
        default:
          pwm <= pwm;
      endcase
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  full_duty_a: assert property (
    fd_active && !tov && mode == MODE_COMPARE && !overflow |=> pwm)
    else $error("full duty not forced");
  duty_latch_a: assert property (!overflow |=> $stable(fd_active))
    else $error("full duty changed mid period");
  ovf_first_a: assert property (
    overflow && tov && match && mode == MODE_COMPARE |=> pwm != $past(pwm))
    else $error("overflow lost to match");
  no_force_a: assert property (
    (tov && !overflow && !match && mode == MODE_COMPARE) [*2]
    |-> $stable(pwm))
    else $error("force acted with toggle on");
endmodule // tmv_chan_out

// ==== tmv_top.sv ====
// Six-channel timer value registers with interlocks and duty override
`timescale 1ns/1ps
module tmv_top
  import tmv_pkg::*;
(
  input  wire logic                            aclk,
  input  wire logic                            aresetn,
  input  wire logic [tmv_pkg::BYTE_ADDR_W-1:0] awaddr,
  input  wire logic                            awvalid,
  output logic                                 awready,
  input  wire logic [31:0]                     wdata,
  input  wire logic [3:0]                      wstrb,
  input  wire logic                            wvalid,
  output logic                                 wready,
  output logic [1:0]                           bresp,
  output logic                                 bvalid,
  input  wire logic                            bready,
  input  wire logic [tmv_pkg::BYTE_ADDR_W-1:0] araddr,
  input  wire logic                            arvalid,
  output logic                                 arready,
  output logic [31:0]                          rdata,
  output logic [1:0]                           rresp,
  output logic                                 rvalid,
  input  wire logic                            rready,
  input  wire logic [tmv_pkg::VAL_W-1:0]       counter,
  input  wire logic                            count_tick,
  input  wire logic                            overflow,
  input  wire logic [tmv_pkg::NCH-1:0]         chan_pin,
  output logic [tmv_pkg::NCH-1:0]              chan_out,
  output logic                                 irq
);
  import tmv_pkg::*;

  // ****************************************************
  // Declarations
  // ****************************************************
  tmv_reg_if rif ();

  logic [VAL_W-1:0]  value [NCH];
  logic [CTRL_W-1:0] ctrl  [NCH];
  logic [NCH-1:0]    cap_block;
  logic [NCH-1:0]    cmp_block;
  logic [NCH-1:0]    pin_prev;
  logic [NCH-1:0]    event_hit;
  logic [NCH-1:0]    match;
  logic [NCH-1:0]    capture;
  logic [NCH-1:0]    status;
  logic [NCH-1:0]    enable;
  logic [NCH-1:0]    wr_hi;
  logic [NCH-1:0]    wr_lo;
  logic [NCH-1:0]    rd_hi;
  logic [NCH-1:0]    rd_lo;
  logic [NCH-1:0]    wr_ctrl;
  logic              wr_clear;
  logic              wr_enable;

  // Any mapped register index
  function automatic logic idx_mapped(input logic [IDX_W-1:0] idx);
    logic found;
    found = (idx == STATUS_IDX) || (idx == CLEAR_IDX)
         || (idx == ENABLE_IDX);
    for (int k = 0; k < NCH; k++)
    begin
      if (idx == VAL_HI_IDX[k] || idx == VAL_LO_IDX[k]
          || idx == CTRL_IDX[k])
        found = 1'b1;
    end
    return found;
  endfunction

  // ****************************************************
  // Bus slave
  // ****************************************************
  tmv_axil u_axil (
    .aclk    (aclk),
    .aresetn (aresetn),
    .awaddr  (awaddr),
    .awvalid (awvalid),
    .awready (awready),
    .wdata   (wdata),
    .wstrb   (wstrb),
    .wvalid  (wvalid),
    .wready  (wready),
    .bresp   (bresp),
    .bvalid  (bvalid),
    .bready  (bready),
    .araddr  (araddr),
    .arvalid (arvalid),
    .arready (arready),
    .rdata   (rdata),
    .rresp   (rresp),
    .rvalid  (rvalid),
    .rready  (rready),
    .rif     (rif.bus)
  );

  assign rif.hit   = idx_mapped(rif.idx);
  assign wr_clear  = rif.wr && rif.idx == CLEAR_IDX;
  assign wr_enable = rif.wr && rif.idx == ENABLE_IDX;

  // Read data mux; unmapped and clear register read zero
  always_comb
  begin
    rif.rdata = 8'h00;
    if (rif.idx == STATUS_IDX)
      rif.rdata = {{(BYTE_W-NCH){1'b0}}, status};
    if (rif.idx == ENABLE_IDX)
      rif.rdata = {{(BYTE_W-NCH){1'b0}}, enable};
    for (int k = 0; k < NCH; k++)
    begin
      if (rif.idx == VAL_HI_IDX[k])
        rif.rdata = value[k][VAL_W-1:HI_LSB];
      if (rif.idx == VAL_LO_IDX[k])
        rif.rdata = value[k][HI_LSB-1:0];
      if (rif.idx == CTRL_IDX[k])
        rif.rdata = {{(BYTE_W-CTRL_W){1'b0}}, ctrl[k]};
    end
  end

  // ****************************************************
  // Channels
  // ****************************************************
  genvar i;
  generate
    for (i = 0; i < NCH; i++)
    begin : g_ch
      tmv_mode_t  mode;
      logic [1:0] els;
      logic       edge_seen;

      assign mode       = tmv_mode(ctrl[i]);
      assign els        = ctrl[i][ELS_LSB+1:ELS_LSB];
      assign wr_hi[i]   = rif.wr && rif.idx == VAL_HI_IDX[i];
      assign wr_lo[i]   = rif.wr && rif.idx == VAL_LO_IDX[i];
      assign rd_hi[i]   = rif.rd && rif.idx == VAL_HI_IDX[i];
      assign rd_lo[i]   = rif.rd && rif.idx == VAL_LO_IDX[i];
      assign wr_ctrl[i] = rif.wr && rif.idx == CTRL_IDX[i];

      // Edge per edge/level select, pin taken as synchronous
      assign edge_seen = (els[0] && chan_pin[i] && !pin_prev[i])
                      || (els[1] && !chan_pin[i] && pin_prev[i]);
      assign capture[i] = mode == MODE_CAPTURE && edge_seen
                       && !cap_block[i];
      assign match[i] = count_tick && counter == value[i]
                     && !cmp_block[i]
                     && (mode == MODE_COMPARE
                         || mode == MODE_BUFFERED);
      assign event_hit[i] = capture[i] || match[i];

      // Control bits
      always_ff @(posedge aclk)
      begin
        if (!aresetn)
          ctrl[i] <= CTRL_RST;
        else if (wr_ctrl[i])
          ctrl[i] <= rif.wdata[CTRL_W-1:0];
      end

      // Pin history for edge detection
      always_ff @(posedge aclk)
      begin
        if (!aresetn)
          pin_prev[i] <= 1'b0;
        else
          pin_prev[i] <= chan_pin[i];
      end

      // Value store, deliberately without reset; capture wins
      always_ff @(posedge aclk)
      begin
        if (wr_hi[i])
          value[i][VAL_W-1:HI_LSB] <= rif.wdata;
        if (wr_lo[i])
          value[i][HI_LSB-1:0] <= rif.wdata;
        if (capture[i])
          value[i] <= counter;
      end

      // Capture interlock: high read until low read
      always_ff @(posedge aclk)
      begin
        if (!aresetn)
          cap_block[i] <= 1'b0;
        else if (rd_lo[i])
          cap_block[i] <= 1'b0;
        else if (rd_hi[i] && mode == MODE_CAPTURE)
          cap_block[i] <= 1'b1;
      end

      // Compare interlock: high write until low write
      always_ff @(posedge aclk)
      begin
        if (!aresetn)
          cmp_block[i] <= 1'b0;
        else if (wr_lo[i])
          cmp_block[i] <= 1'b0;
        else if (wr_hi[i] && ctrl[i][MSB_BIT:MSA_BIT] != 2'b00)
          cmp_block[i] <= 1'b1;
      end

      tmv_chan_out u_out (
        .aclk     (aclk),
        .aresetn  (aresetn),
        .ctrl     (ctrl[i]),
        .overflow (overflow),
        .match    (match[i]),
        .pwm      (chan_out[i])
      );

      // Checks on this channel
      sequence hi_written;
        wr_hi[i] && mode == MODE_COMPARE;
      endsequence
      sequence low_pending;
        !wr_lo[i];
      endsequence

      cap_load_a: assert property (
        @(posedge aclk) disable iff (!aresetn)
        capture[i] |=> value[i] == $past(counter))
        else $error("capture did not latch counter");
      cap_hold_a: assert property (
        @(posedge aclk) disable iff (!aresetn)
        cap_block[i] && !rif.wr |=> $stable(value[i]))
        else $error("capture while high byte read");
      cmp_hold_a: assert property (
        @(posedge aclk) disable iff (!aresetn)
        hi_written ##1 low_pending |-> !event_hit[i])
        else $error("match during high byte write");
      mode_sel_a: assert property (
        @(posedge aclk) disable iff (!aresetn)
        els != ELS_OFF && !ctrl[i][MSB_BIT] && !ctrl[i][MSA_BIT]
        && edge_seen && !cap_block[i] |=> value[i] == $past(counter))
        else $error("capture mode not chosen");
      byte_map_a: assert property (
        @(posedge aclk) disable iff (!aresetn)
        rd_hi[i] |-> rif.rdata == value[i][VAL_W-1:HI_LSB])
        else $error("high byte mapping wrong");

      // Byte stores and low byte read path
      hi_store_a: assert property (
        @(posedge aclk) disable iff (!aresetn)
        wr_hi[i] && !capture[i]
        |=> value[i][VAL_W-1:HI_LSB] == $past(rif.wdata))
        else $error("high byte write lost");
      lo_store_a: assert property (
        @(posedge aclk) disable iff (!aresetn)
        wr_lo[i] && !capture[i]
        |=> value[i][HI_LSB-1:0] == $past(rif.wdata))
        else $error("low byte write lost");
      lo_map_a: assert property (
        @(posedge aclk) disable iff (!aresetn)
        rd_lo[i] |-> rif.rdata == value[i][HI_LSB-1:0])
        else $error("low byte mapping wrong");
      ctrl_write_a: assert property (
        @(posedge aclk) disable iff (!aresetn)
        wr_ctrl[i] |=> ctrl[i] == $past(rif.wdata[CTRL_W-1:0]))
        else $error("control write lost");

      // Interlocks close on the high byte and open on the low byte
      cap_lock_a: assert property (
        @(posedge aclk) disable iff (!aresetn)
        rd_hi[i] && mode == MODE_CAPTURE |=> cap_block[i])
        else $error("high read did not hold captures");
      cap_free_a: assert property (
        @(posedge aclk) disable iff (!aresetn)
        rd_lo[i] |=> !cap_block[i])
        else $error("low read did not free captures");
      cmp_lock_a: assert property (
        @(posedge aclk) disable iff (!aresetn)
        wr_hi[i] && (mode == MODE_COMPARE || mode == MODE_BUFFERED)
        |=> cmp_block[i])
        else $error("high write did not hold matches");
      cmp_free_a: assert property (
        @(posedge aclk) disable iff (!aresetn)
        wr_lo[i] |=> !cmp_block[i])
        else $error("low write did not free matches");

      // Event flag: set beats clear, clear works, otherwise sticky
      flag_set_a: assert property (
        @(posedge aclk) disable iff (!aresetn)
        event_hit[i] |=> status[i])
        else $error("event flag not set");
      flag_clear_a: assert property (
        @(posedge aclk) disable iff (!aresetn)
        wr_clear && rif.wdata[i] && !event_hit[i] |=> !status[i])
        else $error("event flag not cleared");
      flag_hold_a: assert property (
        @(posedge aclk) disable iff (!aresetn)
        !event_hit[i] && !wr_clear |=> $stable(status[i]))
        else $error("event flag changed unprompted");
    end
  endgenerate

  // ****************************************************
  // Event status and interrupt
  // ****************************************************
  // Set beats clear so an event in the clear cycle is kept
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      status <= IRQ_RST;
    else if (wr_clear)
      status <= (status & ~rif.wdata[NCH-1:0]) | event_hit;
    else
      status <= status | event_hit;
  end

  // Interrupt enable
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      enable <= IRQ_RST;
    else if (wr_enable)
      enable <= rif.wdata[NCH-1:0];
  end

  assign irq = |(status & enable);

  sticky_set_a: assert property (@(posedge aclk) disable iff (!aresetn)
    event_hit[0] |=> status[0] ##1 (status[0] || $past(wr_clear)))
    else $error("event flag lost");

  // ****************************************************
  // Bus response checks
  // ****************************************************
  // Every taken write is answered at the next edge
  write_answer_a: assert property (@(posedge aclk) disable iff (!aresetn)
    awready |=> bvalid)
    else $error("write not answered");

  // Unmapped index must not look like a good write
  bad_addr_a: assert property (@(posedge aclk) disable iff (!aresetn)
    awready && !rif.hit |=> bvalid && bresp == RESP_SLVERR)
    else $error("unmapped write not refused");

  // Byte registers leave the upper lanes at zero
  read_pad_a: assert property (@(posedge aclk) disable iff (!aresetn)
    arready |=> rvalid && rdata[31:BYTE_W] == 24'h00_0000)
    else $error("read answer malformed");

  // Enable register takes the written mask
  enable_write_a: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_enable |=> enable == $past(rif.wdata[NCH-1:0]))
    else $error("enable write lost");
endmodule // tmv_top

// ==== timer_channel_value_regs_test.sv ====
// Self-checking bench for the timer channel value block
`timescale 1ns/1ps
`define CHK(got, exp) \
  begin \
    checks++; \
    if ((got) !== (exp)) \
    begin \
      err_count++; \
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp); \
    end \
  end

module timer_channel_value_regs_test;
  import tmv_pkg::*;

  // ****************************************************************
  // Signals
  // ****************************************************************
  logic                   aclk;
  logic                   aresetn;
  logic [BYTE_ADDR_W-1:0] awaddr;
  logic                   awvalid;
  logic                   awready;
  logic [31:0]            wdata;
  logic [3:0]             wstrb;
  logic                   wvalid;
  logic                   wready;
  logic [1:0]             bresp;
  logic                   bvalid;
  logic                   bready;
  logic [BYTE_ADDR_W-1:0] araddr;
  logic                   arvalid;
  logic                   arready;
  logic [31:0]            rdata;
  logic [1:0]             rresp;
  logic                   rvalid;
  logic                   rready;
  logic [VAL_W-1:0]       counter;
  logic                   count_tick;
  logic                   overflow;
  logic [NCH-1:0]         chan_pin;
  logic [NCH-1:0]         chan_out;
  logic                   irq;
  logic [1:0]             resp;
  logic                   o;
  int                     err_count;
  int                     checks;
  int                     cycles;

  tmv_top dut (
    .aclk       (aclk),
    .aresetn    (aresetn),
    .awaddr     (awaddr),
    .awvalid    (awvalid),
    .awready    (awready),
    .wdata      (wdata),
    .wstrb      (wstrb),
    .wvalid     (wvalid),
    .wready     (wready),
    .bresp      (bresp),
    .bvalid     (bvalid),
    .bready     (bready),
    .araddr     (araddr),
    .arvalid    (arvalid),
    .arready    (arready),
    .rdata      (rdata),
    .rresp      (rresp),
    .rvalid     (rvalid),
    .rready     (rready),
    .counter    (counter),
    .count_tick (count_tick),
    .overflow   (overflow),
    .chan_pin   (chan_pin),
    .chan_out   (chan_out),
    .irq        (irq)
  );

  // ****************************************************************
  // Clock, timeout and verdict
  // ****************************************************************
  // Free running 250 MHz clock
  initial
  begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end

  // Whole run needs a few hundred cycles, so this only catches hangs
  always @(posedge aclk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      err_count++;
      results();
    end
  end

  task automatic results;
    if (err_count == 0 && checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // ****************************************************************
  // Bus and event tasks
  // ****************************************************************
  // Address and data offered together; ready lines stay high throughout
  task automatic wr(input logic [IDX_W-1:0] idx, input logic [7:0] d,
                    input logic [3:0] st = 4'hf);
    awaddr  <= {idx, 2'b00};
    wdata   <= {24'h0, d};
    wstrb   <= st;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    do @(posedge aclk); while (awready !== 1'b1);
    awvalid <= 1'b0;
    wvalid  <= 1'b0;
    do @(posedge aclk); while (bvalid !== 1'b1);
    resp = bresp;
  endtask

  // Read one byte register and compare the whole data word
  task automatic rdc(input logic [IDX_W-1:0] idx, input logic [7:0] exp);
    araddr  <= {idx, 2'b00};
    arvalid <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge aclk); while (rvalid !== 1'b1);
    resp = rresp;
    `CHK(rdata, {24'h0, exp})
  endtask

  // One-cycle tick and/or overflow, then let outputs settle
  task automatic ev(input logic tk, input logic ov, input logic [15:0] c);
    counter    <= c;
    count_tick <= tk;
    overflow   <= ov;
    @(posedge aclk);
    count_tick <= 1'b0;
    overflow   <= 1'b0;
    repeat (2) @(posedge aclk);
  endtask

  // Rising edge on channel 1 pin with the counter parked at c
  task automatic rise(input logic [15:0] c);
    counter     <= c;
    chan_pin[1] <= 1'b0;
    repeat (2) @(posedge aclk);
    chan_pin[1] <= 1'b1;
    repeat (3) @(posedge aclk);
  endtask

  // ****************************************************************
  // Test sequence
  // ****************************************************************
  initial
  begin
    aresetn    = 1'b0;
    awaddr     = '0;
    awvalid    = 1'b0;
    wdata      = '0;
    wstrb      = '0;
    wvalid     = 1'b0;
    bready     = 1'b1;
    araddr     = '0;
    arvalid    = 1'b0;
    rready     = 1'b1;
    counter    = '0;
    count_tick = 1'b0;
    overflow   = 1'b0;
    chan_pin   = '0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    `CHK(chan_out, {NCH{OUT_RST}})
    `CHK(irq, 1'b0)
    for (int ch = 0; ch < NCH; ch++)
      rdc(CTRL_IDX[ch], 8'h00);
    rdc(STATUS_IDX, 8'h00);
    rdc(ENABLE_IDX, 8'h00);
    // Distinct bytes per channel catch swapped or aliased registers
    for (int ch = 0; ch < NCH; ch++)
    begin
      wr(VAL_HI_IDX[ch], 8'ha0 + 8'(ch));
      wr(VAL_LO_IDX[ch], 8'h50 + 8'(ch));
      rdc(VAL_HI_IDX[ch], 8'ha0 + 8'(ch));
      rdc(VAL_LO_IDX[ch], 8'h50 + 8'(ch));
    end
    wr(VAL_HI_IDX[0], 8'hff, 4'h0);
    rdc(VAL_HI_IDX[0], 8'ha0);
    wr(7'h00, 8'h11);
    `CHK(resp, RESP_SLVERR)
    rdc(7'h00, 8'h00);
    `CHK(resp, RESP_SLVERR)
    // Port mode with unbuffered select set drives the idle level low
    wr(CTRL_IDX[5], 8'h10);
    repeat (2) @(posedge aclk);
    `CHK(chan_out[5], 1'b0)
    rdc(CTRL_IDX[5], 8'h10);

    // Channel 0 compare with toggle, interrupt raised, masked, cleared
    wr(ENABLE_IDX, 8'h01);
    wr(CTRL_IDX[0], 8'h14);
    wr(VAL_HI_IDX[0], 8'h12);
    wr(VAL_LO_IDX[0], 8'h34);
    o = chan_out[0];
    ev(1'b1, 1'b0, 16'h1234);
    `CHK(chan_out[0], ~o)
    `CHK(irq, 1'b1)
    rdc(STATUS_IDX, 8'h01);
    wr(CLEAR_IDX, 8'h01);
    `CHK(irq, 1'b0)
    rdc(CLEAR_IDX, 8'h00);
    wr(VAL_HI_IDX[0], 8'h12);
    ev(1'b1, 1'b0, 16'h1234);
    `CHK(chan_out[0], ~o)
    rdc(STATUS_IDX, 8'h00);
    wr(ENABLE_IDX, 8'h00);
    wr(VAL_LO_IDX[0], 8'h34);
    ev(1'b1, 1'b0, 16'h1234);
    `CHK(chan_out[0], o)
    `CHK(irq, 1'b0)
    wr(ENABLE_IDX, 8'h01);
    `CHK(irq, 1'b1)
    wr(CLEAR_IDX, 8'h01);
    wr(ENABLE_IDX, 8'h00);
    rdc(STATUS_IDX, 8'h00);

    // Channel 1 capture on rising edge, high read holds the value
    wr(CTRL_IDX[1], 8'h04);
    rise(16'h0abc);
    rdc(VAL_HI_IDX[1], 8'h0a);
    rise(16'h0def);
    rdc(VAL_LO_IDX[1], 8'hbc);
    rise(16'h0def);
    rdc(VAL_HI_IDX[1], 8'h0d);
    rdc(VAL_LO_IDX[1], 8'hef);
    rdc(STATUS_IDX, 8'h02);

    // Full duty on unbuffered channel 2 and buffered channel 4
    wr(VAL_HI_IDX[2], 8'h01);
    wr(VAL_LO_IDX[2], 8'h00);
    wr(VAL_HI_IDX[4], 8'h01);
    wr(VAL_LO_IDX[4], 8'h00);
    wr(CTRL_IDX[2], 8'h19);
    wr(CTRL_IDX[4], 8'h29);
    ev(1'b1, 1'b0, 16'h0100);
    `CHK({chan_out[4], chan_out[2]}, 2'b00)
    ev(1'b0, 1'b1, 16'h0000);
    `CHK({chan_out[4], chan_out[2]}, 2'b11)
    ev(1'b1, 1'b0, 16'h0100);
    `CHK({chan_out[4], chan_out[2]}, 2'b11)
    wr(CTRL_IDX[2], 8'h18);
    wr(CTRL_IDX[4], 8'h28);
    ev(1'b1, 1'b0, 16'h0100);
    `CHK({chan_out[4], chan_out[2]}, 2'b11)
    ev(1'b0, 1'b1, 16'h0000);
    ev(1'b1, 1'b0, 16'h0100);
    `CHK({chan_out[4], chan_out[2]}, 2'b00)

    // Channel 3 toggle on overflow beats a coincident clear on compare
    wr(VAL_HI_IDX[3], 8'h02);
    wr(VAL_LO_IDX[3], 8'h00);
    wr(CTRL_IDX[3], 8'h1b);
    ev(1'b1, 1'b0, 16'h0200);
    `CHK(chan_out[3], 1'b0)
    ev(1'b1, 1'b1, 16'h0200);
    `CHK(chan_out[3], 1'b1)
    ev(1'b1, 1'b1, 16'h0200);
    `CHK(chan_out[3], 1'b0)

    // Set on compare and falling-edge capture, not used above
    wr(CTRL_IDX[2], 8'h1c);
    ev(1'b1, 1'b0, 16'h0100);
    `CHK(chan_out[2], 1'b1)
    wr(CTRL_IDX[1], 8'h08);
    rise(16'h0123);
    rdc(VAL_HI_IDX[1], 8'h01);
    rdc(VAL_LO_IDX[1], 8'h23);
    results();
  end
endmodule // timer_channel_value_regs_test
